// ### logic/lst_timers.sv
// line state noise timer and state duration timer with control bus registers
`timescale 1ns/100ps
`default_nettype none

// How it works
// - noise prescale at zero reloads and steps noise counter down once
// - both noise counters zero in noisy state reload both from thresholds
// - halt, idle, master, quiet or no signal hold noise counters at thresholds
// - writing either noise threshold loads both noise counters at once
// - change into noisy states keeps noise counters running, no reload
// - noise counter and prescale both zero raise the noise threshold event
// - noise count read gives counter snapshot low seven bits, change flag bit 7
// - writes to snapshot registers change nothing and raise write reject
// - noise prescale count read gives eight bit snapshot taken that cycle
// - state counter steps only with state prescale zero in quiet-type state
// - state counter and state prescale both reach zero after ((spt+1)*st+spt) steps of 80 ns
// - both state counters zero in quiet-type state reload both
// - change into quiet-type state restarts both state counters
// - writing either state threshold loads both state counters
// - state prescale at zero reloads from its threshold
// - active, noise or unknown line state freeze the state counter
// - state threshold holds seven bit start value in bits 0 to 6
// - top bit of state threshold reads zero, writes to it dropped
// - noise counter steps every 80*(npt+1) ns in noisy states
// - noise threshold holds seven bit start value in bits 0 to 6
// - state prescale steps every 80 ns only in quiet-type states
module lst_timers #(
   parameter int unsigned STEP_CYCLES = lst_pkg::STEP_CYCLES
) (
   input  wire logic            clk_sys,
   input  wire logic            sys_rst,
   input  wire lst_pkg::lst_ls_e line_state,
   input  wire logic            line_state_change,
   input  wire logic [4:0]      cb_addr,
   input  wire logic            cb_rd,
   input  wire logic            cb_wr,
   input  wire logic [7:0]      cb_wdata,
   output logic      [7:0]      cb_rdata,
   output logic                 noise_event_time_limit,
   output logic                 state_threshold_event,
   output logic                 write_command_reject_flag
);

   localparam int DIV_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

   generate
      if (STEP_CYCLES < 1) begin : g_bad_step
         $error("lst_timers: STEP_CYCLES must be at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [6:0]       noise_threshold;
      logic [7:0]       noise_prescale_threshold;
      logic [6:0]       noise_count;
      logic [7:0]       noise_prescale_count;
      logic [6:0]       state_duration_threshold;
      logic [7:0]       state_prescale_threshold;
      logic [6:0]       state_count;
      logic [7:0]       state_prescale_count;
      logic             noise_counter_change_flag;
      logic             state_counter_change_flag;
      logic [DIV_W-1:0] div;
      logic [7:0]       rdata;
      logic             noise_hit;
      logic             state_hit;
      logic             reject;
   } lst_state_s;

   lst_state_s q;
   lst_state_s next_q;

   logic step;
   logic quiet;
   logic wr_noise_thr;
   logic wr_state_thr;
   logic wr_snap;
   logic rd_noise_snap;
   logic rd_state_snap;

   // one-cycle enable every 80 ns
   assign step  = (q.div == '0);
   assign quiet = lst_pkg::lst_is_quiet(line_state);

   assign wr_noise_thr  = cb_wr && (cb_addr == lst_pkg::ADDR_NOISE_THRESHOLD ||
                                    cb_addr == lst_pkg::ADDR_NOISE_PRESCALE_THR);
   assign wr_state_thr  = cb_wr && (cb_addr == lst_pkg::ADDR_STATE_DURATION_THR ||
                                    cb_addr == lst_pkg::ADDR_STATE_PRESCALE_THR);
   assign wr_snap       = cb_wr && (cb_addr == lst_pkg::ADDR_NOISE_COUNT_SNAP ||
                                    cb_addr == lst_pkg::ADDR_NOISE_PRESCALE_SNAP ||
                                    cb_addr == lst_pkg::ADDR_STATE_COUNT_SNAP ||
                                    cb_addr == lst_pkg::ADDR_STATE_PRESCALE_SNAP);
   assign rd_noise_snap = cb_rd && (cb_addr == lst_pkg::ADDR_NOISE_COUNT_SNAP);
   assign rd_state_snap = cb_rd && (cb_addr == lst_pkg::ADDR_STATE_COUNT_SNAP);

   always_comb begin
      next_q           = q;
      next_q.noise_hit = 1'b0;
      next_q.state_hit = 1'b0;
      next_q.div       = (q.div == DIV_LAST) ? '0 : q.div + 1'b1;

      if (cb_wr) begin
         if (cb_addr == lst_pkg::ADDR_NOISE_THRESHOLD) begin
            next_q.noise_threshold = cb_wdata[6:0];
         end else if (cb_addr == lst_pkg::ADDR_NOISE_PRESCALE_THR) begin
            next_q.noise_prescale_threshold = cb_wdata;
         end else if (cb_addr == lst_pkg::ADDR_STATE_DURATION_THR) begin
            next_q.state_duration_threshold = cb_wdata[6:0];
         end else if (cb_addr == lst_pkg::ADDR_STATE_PRESCALE_THR) begin
            next_q.state_prescale_threshold = cb_wdata;
         end
      end
      next_q.reject = wr_snap;

      // noise timer
      if (wr_noise_thr) begin
         // load from the freshly written values
         next_q.noise_count          = next_q.noise_threshold;
         next_q.noise_prescale_count = next_q.noise_prescale_threshold;
      end else if (quiet) begin
         next_q.noise_count          = q.noise_threshold;
         next_q.noise_prescale_count = q.noise_prescale_threshold;
      end else if (step) begin
         // noisy states keep counting from present values
         if (q.noise_count == '0 && q.noise_prescale_count == '0) begin
            next_q.noise_count          = q.noise_threshold;
            next_q.noise_prescale_count = q.noise_prescale_threshold;
            next_q.noise_hit            = 1'b1;
         end else if (q.noise_prescale_count == '0) begin
            next_q.noise_prescale_count = q.noise_prescale_threshold;
            next_q.noise_count          = q.noise_count - 1'b1;
         end else begin
            next_q.noise_prescale_count = q.noise_prescale_count - 1'b1;
         end
      end

      // state timer
      if (wr_state_thr) begin
         // load from the freshly written values
         next_q.state_count          = next_q.state_duration_threshold;
         next_q.state_prescale_count = next_q.state_prescale_threshold;
      end else if (quiet && line_state_change) begin
         next_q.state_count          = q.state_duration_threshold;
         next_q.state_prescale_count = q.state_prescale_threshold;
      end else if (quiet && step) begin
         // count down only in quiet-type states
         if (q.state_count == '0 && q.state_prescale_count == '0) begin
            next_q.state_count          = q.state_duration_threshold;
            next_q.state_prescale_count = q.state_prescale_threshold;
            next_q.state_hit            = 1'b1;
         end else if (q.state_prescale_count == '0) begin
            next_q.state_prescale_count = q.state_prescale_threshold;
            next_q.state_count          = q.state_count - 1'b1;
         end else begin
            next_q.state_prescale_count = q.state_prescale_count - 1'b1;
         end
      end
      // otherwise the state counters stand still

      // change flags: cleared by reading their register, a new change wins
      if (rd_noise_snap) begin
         next_q.noise_counter_change_flag = 1'b0;
      end
      if (rd_state_snap) begin
         next_q.state_counter_change_flag = 1'b0;
      end
      if (line_state_change) begin
         next_q.noise_counter_change_flag = 1'b1;
         next_q.state_counter_change_flag = 1'b1;
      end

      // read data, snapshots taken in the read cycle
      if (!cb_rd) begin
         next_q.rdata = q.rdata;
      end else if (cb_addr == lst_pkg::ADDR_NOISE_THRESHOLD) begin
         next_q.rdata = {1'b0, q.noise_threshold};
      end else if (cb_addr == lst_pkg::ADDR_NOISE_PRESCALE_THR) begin
         next_q.rdata = q.noise_prescale_threshold;
      end else if (cb_addr == lst_pkg::ADDR_NOISE_COUNT_SNAP) begin
         next_q.rdata = {q.noise_counter_change_flag, q.noise_count};
      end else if (cb_addr == lst_pkg::ADDR_NOISE_PRESCALE_SNAP) begin
         next_q.rdata = q.noise_prescale_count;
      end else if (cb_addr == lst_pkg::ADDR_STATE_DURATION_THR) begin
         next_q.rdata = {1'b0, q.state_duration_threshold};
      end else if (cb_addr == lst_pkg::ADDR_STATE_PRESCALE_THR) begin
         next_q.rdata = q.state_prescale_threshold;
      end else if (cb_addr == lst_pkg::ADDR_STATE_COUNT_SNAP) begin
         next_q.rdata = {q.state_counter_change_flag, q.state_count};
      end else if (cb_addr == lst_pkg::ADDR_STATE_PRESCALE_SNAP) begin
         next_q.rdata = q.state_prescale_count;
      end else begin
         next_q.rdata = lst_pkg::UNMAPPED_READ;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign cb_rdata                  = q.rdata;
   assign noise_event_time_limit    = q.noise_hit;
   assign state_threshold_event     = q.state_hit;
   assign write_command_reject_flag = q.reject;

   noise_prescale_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (step && !quiet && !wr_noise_thr && q.noise_prescale_count == 8'h00 &&
       q.noise_count != 7'h00) |=>
      (q.noise_prescale_count == $past(q.noise_prescale_threshold) &&
       q.noise_count == $past(q.noise_count) - 7'h01))
      else $error("noise prescale wrap did not reload and step");

   noise_expiry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (step && !quiet && !wr_noise_thr && q.noise_count == 7'h00 &&
       q.noise_prescale_count == 8'h00) |=>
      (noise_event_time_limit && q.noise_count == $past(q.noise_threshold)))
      else $error("noise expiry not flagged or not reloaded");

   noise_quiet_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (quiet && !wr_noise_thr) |=>
      (q.noise_count == $past(q.noise_threshold) &&
       q.noise_prescale_count == $past(q.noise_prescale_threshold)))
      else $error("noise counters not held at thresholds");

   noise_write_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wr_noise_thr |=> (q.noise_count == q.noise_threshold &&
                        q.noise_prescale_count == q.noise_prescale_threshold))
      else $error("noise threshold write did not load counters");

   // no reload on change into noisy state, only the normal step
   noise_keep_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (line_state_change && !quiet && !wr_noise_thr && q.noise_prescale_count != 8'h00) |=>
      (q.noise_prescale_count == $past(q.noise_prescale_count) - {7'h00, $past(step)} &&
       $stable(q.noise_count)))
      else $error("noise counters disturbed by line state change");

   noise_snap_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      rd_noise_snap |=> (cb_rdata[6:0] == $past(q.noise_count)))
      else $error("noise count snapshot mismatch");

   snap_write_reject_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wr_snap |=> write_command_reject_flag ##1 (write_command_reject_flag == $past(wr_snap)))
      else $error("snapshot write not rejected");

   state_entry_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (quiet && line_state_change && !wr_state_thr) |=>
      (q.state_count == $past(q.state_duration_threshold) &&
       q.state_prescale_count == $past(q.state_prescale_threshold)))
      else $error("state counters not restarted");

   state_freeze_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!quiet && !wr_state_thr) |=> $stable(q.state_count))
      else $error("state counter moved in noisy line state");

   state_thr_top_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cb_rd && cb_addr == lst_pkg::ADDR_STATE_DURATION_THR) |=> (cb_rdata[7] == 1'b0))
      else $error("state threshold top bit not zero");

endmodule

`default_nettype wire

// ### logic/lst_pkg.sv
// constants, types and helpers for the line state noise and state timers
package lst_pkg;

   // control bus addresses of the timer registers
   localparam logic [4:0] ADDR_NOISE_THRESHOLD      = 5'h0d;
   localparam logic [4:0] ADDR_NOISE_PRESCALE_THR   = 5'h0e;
   localparam logic [4:0] ADDR_NOISE_COUNT_SNAP     = 5'h0f;
   localparam logic [4:0] ADDR_NOISE_PRESCALE_SNAP  = 5'h10;
   localparam logic [4:0] ADDR_STATE_DURATION_THR   = 5'h11;
   localparam logic [4:0] ADDR_STATE_PRESCALE_THR   = 5'h12;
   localparam logic [4:0] ADDR_STATE_COUNT_SNAP     = 5'h13;
   localparam logic [4:0] ADDR_STATE_PRESCALE_SNAP  = 5'h14;

   // field layout of threshold and snapshot registers
   localparam int         COUNT_W       = 7;
   localparam int         PRESCALE_W    = 8;
   localparam int         CHANGE_FLAG_BIT = 7;

   // reset values
   localparam logic [6:0] COUNT_RST     = 7'h00;
   localparam logic [7:0] PRESCALE_RST  = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // timing: one timer step every 80 ns, derived from the 20 ns system clock
   localparam int         STEP_NS       = 80;
   localparam int         CLK_NS        = 20;
   localparam int         STEP_CYCLES   = (STEP_NS / CLK_NS < 1) ? 1 : STEP_NS / CLK_NS;

   // line state reported by the receive line state detector
   typedef enum logic [2:0] {
      halt_line_state,
      idle_line_state,
      master_line_state,
      quiet_line_state,
      no_signal_detect,
      active_line_state,
      noise_line_state,
      unknown_line_state
   } lst_ls_e;

   // states in which the noise timer is held and the state timer runs
   function automatic logic lst_is_quiet(input lst_ls_e ls);
      return (ls == halt_line_state) || (ls == idle_line_state) ||
             (ls == master_line_state) || (ls == quiet_line_state) ||
             (ls == no_signal_detect);
   endfunction

endpackage

// ### tb/lst_cb_host.sv
// control bus master model standing in for the management processor
`timescale 1ns/100ps
`default_nettype none
module lst_cb_host (
   input  wire logic       clk_sys,
   output logic [4:0]      cb_addr,
   output logic            cb_rd,
   output logic            cb_wr,
   output logic [7:0]      cb_wdata,
   input  wire logic [7:0] cb_rdata
);
   initial begin
      cb_addr  = 5'h00;
      cb_rd    = 1'b0;
      cb_wr    = 1'b0;
      cb_wdata = 8'h00;
   end
   // released lines are inverted so stale values are never trusted
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      cb_addr  <= a;
      cb_wdata <= d;
      cb_wr    <= 1'b1;
      @(posedge clk_sys);
      cb_wr    <= 1'b0;
      cb_addr  <= ~a;
      cb_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      cb_addr <= a;
      cb_rd   <= 1'b1;
      @(posedge clk_sys);
      cb_rd   <= 1'b0;
      cb_addr <= ~a;
      #1;
      d = cb_rdata;
   endtask
endmodule
`default_nettype wire

// ### tb/test_line_state_noise_timers.sv
// self-checking testbench for the line state noise and state timers
`timescale 1ns/100ps
`default_nettype none
module test_line_state_noise_timers;
   logic             clk_sys;
   logic             sys_rst;
   lst_pkg::lst_ls_e line_state;
   logic             line_state_change;
   logic [4:0]       cb_addr;
   logic             cb_rd;
   logic             cb_wr;
   logic [7:0]       cb_wdata;
   logic [7:0]       cb_rdata;
   logic             noise_event_time_limit;
   logic             state_threshold_event;
   logic             write_command_reject_flag;
   int               n_mismatch;
   int               tests_run;
   int               cycles = 0;
   int               g;
   logic [7:0]       v;
   logic [7:0]       v2;
   // snapshot registers that must refuse writes
   logic [4:0]       g_addr [4] = '{5'h0f, 5'h10, 5'h13, 5'h14};
   lst_timers #(.STEP_CYCLES(lst_pkg::STEP_CYCLES)) i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .line_state(line_state),
      .line_state_change(line_state_change), .cb_addr(cb_addr), .cb_rd(cb_rd),
      .cb_wr(cb_wr), .cb_wdata(cb_wdata), .cb_rdata(cb_rdata),
      .noise_event_time_limit(noise_event_time_limit),
      .state_threshold_event(state_threshold_event),
      .write_command_reject_flag(write_command_reject_flag));
   lst_cb_host i_host (
      .clk_sys(clk_sys), .cb_addr(cb_addr), .cb_rd(cb_rd), .cb_wr(cb_wr),
      .cb_wdata(cb_wdata), .cb_rdata(cb_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic close_out;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ls_to(input lst_pkg::lst_ls_e s);
      @(posedge clk_sys);
      line_state        <= s;
      line_state_change <= 1'b1;
      @(posedge clk_sys);
      line_state_change <= 1'b0;
   endtask
   // cycles between two successive expiry pulses of the chosen timer
   task automatic gap(input logic sel, output int n);
      logic p;
      p = 1'b0;
      n = 0;
      for (int i = 0; i < 1000 && !p; i++) begin
         @(posedge clk_sys);
         #1 p = sel ? noise_event_time_limit === 1'b1 : state_threshold_event === 1'b1;
      end
      p = 1'b0;
      while (!p && n < 1000) begin
         @(posedge clk_sys);
         #1 p = sel ? noise_event_time_limit === 1'b1 : state_threshold_event === 1'b1;
         n++;
      end
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      n_mismatch        = 0;
      tests_run         = 0;
      sys_rst           = 1'b1;
      line_state        = lst_pkg::idle_line_state;
      line_state_change = 1'b0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int a = 13; a <= 20; a++) begin
         i_host.rd(5'(a), v);
         chk(v, 8'h00);
      end
      i_host.wr(5'h0d, 8'hff);
      i_host.rd(5'h0d, v);
      chk(v, 8'h7f);
      i_host.wr(5'h0e, 8'ha5);
      i_host.rd(5'h0e, v);
      chk(v, 8'ha5);
      i_host.wr(5'h11, 8'hff);
      i_host.rd(5'h11, v);
      chk(v, 8'h7f);
      foreach (g_addr[k]) begin
         i_host.wr(g_addr[k], 8'h3c);
         chk({7'h00, write_command_reject_flag}, 8'h01);
      end
      ls_to(lst_pkg::quiet_line_state);
      i_host.rd(5'h0f, v);
      chk(v, 8'hff);
      i_host.rd(5'h0f, v);
      chk(v, 8'h7f);
      i_host.wr(5'h12, 8'h01);
      i_host.wr(5'h11, 8'h03);
      gap(1'b0, g);
      // ((1+1)*3+1) steps to zero plus the reload step, each step one divider period
      chk(8'(g), 8'(8 * lst_pkg::STEP_CYCLES));
      i_host.wr(5'h0d, 8'h02);
      i_host.wr(5'h0e, 8'h02);
      ls_to(lst_pkg::noise_line_state);
      gap(1'b1, g);
      // ((2+1)*2+2) steps to zero plus the reload step
      chk(8'(g), 8'(9 * lst_pkg::STEP_CYCLES));
      i_host.rd(5'h13, v);
      repeat (50) @(posedge clk_sys);
      i_host.rd(5'h13, v2);
      chk(v2 & 8'h7f, v & 8'h7f);
      i_host.wr(5'h0e, 8'hff);
      i_host.rd(5'h10, v);
      // two snapshots one divider period apart differ by exactly one step
      repeat (lst_pkg::STEP_CYCLES - 2) @(posedge clk_sys);
      i_host.rd(5'h10, v2);
      chk(8'(v - v2), 8'h01);
      i_host.wr(5'h0d, 8'h20);
      i_host.rd(5'h0f, v);
      chk(v & 8'h7f, 8'h20);
      // one noise step takes 256 prescale steps here
      repeat (1100) @(posedge clk_sys);
      i_host.rd(5'h0f, v);
      ls_to(lst_pkg::active_line_state);
      i_host.rd(5'h0f, v2);
      chk({7'h00, (v2 & 8'h7f) < 8'h20 && (v2 & 8'h7f) <= (v & 8'h7f)}, 8'h01);
      ls_to(lst_pkg::idle_line_state);
      i_host.wr(5'h12, 8'h40);
      i_host.wr(5'h11, 8'h03);
      i_host.rd(5'h13, v);
      chk(v & 8'h7f, 8'h03);
      // one state step takes 65 prescale steps here
      repeat (300) @(posedge clk_sys);
      i_host.rd(5'h13, v);
      chk({7'h00, (v & 8'h7f) < 8'h03}, 8'h01);
      ls_to(lst_pkg::master_line_state);
      i_host.rd(5'h13, v);
      chk(v & 8'h7f, 8'h03);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      i_host.rd(5'h11, v);
      chk(v, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
